//--- antdrv_pkg.sv
// Package: constants and types of the antenna driver output select block
package antdrv_pkg;
  // Carrier derivation
  localparam int OSC_FREQ_KHZ = 27120;
  localparam int CARRIER_DIV = 2;
  localparam int CARRIER_FREQ_KHZ = OSC_FREQ_KHZ / CARRIER_DIV;
  // Conductance widths
  localparam int P_COND_W = 6;
  localparam int N_COND_W = 4;
  // Register byte offsets
  localparam logic [7:0] CTRL_REG_OFS = 8'h00;
  localparam logic [7:0] P_UNMOD_REG_OFS = 8'h04;
  localparam logic [7:0] P_KEYED_REG_OFS = 8'h08;
  localparam logic [7:0] N_COND_REG_OFS = 8'h0C;
  localparam logic [7:0] STATUS_REG_OFS = 8'h10;
  // Control register fields
  localparam int CTRL_A_EN_BIT = 0;
  localparam int CTRL_B_EN_BIT = 1;
  localparam int CTRL_FORCE_BIT = 2;
  localparam int CTRL_A_INV_ON_BIT = 3;
  localparam int CTRL_A_INV_OFF_BIT = 4;
  localparam int CTRL_B_CW_BIT = 5;
  localparam int CTRL_B_INV_ON_BIT = 6;
  localparam int CTRL_B_INV_OFF_BIT = 7;
  // N conductance register fields
  localparam int N_UNMOD_LSB = 4;
  localparam int N_KEYED_LSB = 0;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [P_COND_W-1:0] P_UNMOD_RST = 6'h3F;
  localparam logic [P_COND_W-1:0] P_KEYED_RST = 6'h20;
  localparam logic [7:0] N_COND_RST = 8'h88;
  // AXI responses
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // Waveform choice for one pin
  typedef enum logic [1:0] {WAVE_ZERO, WAVE_CARRIER, WAVE_INVERTED} antdrv_wave_e;
  // Registered control snapshot
  typedef struct packed {
    logic envelope;
    logic [7:0] ctrl;
  } antdrv_snap_s;
endpackage : antdrv_pkg

//--- antdrv_sel_if.sv
// Interface: snapshot in, pin selections out
`timescale 1ns/1ps
`default_nettype none
interface antdrv_sel_if;
  import antdrv_pkg::*;
  antdrv_snap_s snap;
  antdrv_wave_e wave_a;
  antdrv_wave_e wave_b;
  logic unmod_a;
  logic unmod_b;
  logic active_a;
  logic active_b;
  modport ctl (output snap, input wave_a, wave_b, unmod_a, unmod_b, active_a, active_b);
  modport sel (input snap, output wave_a, wave_b, unmod_a, unmod_b, active_a, active_b);
endinterface : antdrv_sel_if
`default_nettype wire

//--- antdrv_select.sv
// Module: per-pin waveform and conductance selection
`timescale 1ns/1ps
`default_nettype none
module antdrv_select
  import antdrv_pkg::*;
(
  // Snapshot and selections
  antdrv_sel_if.sel sif
);
  // Named control bits
  wire env = sif.snap.envelope;
  wire en_a = sif.snap.ctrl[CTRL_A_EN_BIT];
  wire en_b = sif.snap.ctrl[CTRL_B_EN_BIT];
  wire force_full_depth_keying = sif.snap.ctrl[CTRL_FORCE_BIT];
  wire driver_a_invert_when_on = sif.snap.ctrl[CTRL_A_INV_ON_BIT];
  wire driver_b_always_unmodulated = sif.snap.ctrl[CTRL_B_CW_BIT];
  wire driver_b_invert_when_on = sif.snap.ctrl[CTRL_B_INV_ON_BIT];
  // Pause with full depth keying pulls pin low, pin B only when not always unmodulated
  wire hold_low_a = force_full_depth_keying && !env;
  wire hold_low_b = force_full_depth_keying && !env && !driver_b_always_unmodulated;
  antdrv_wave_e run_a;
  antdrv_wave_e run_b;
  // Carrier polarity from the on-inversion bits
  assign run_a = driver_a_invert_when_on ? WAVE_INVERTED : WAVE_CARRIER;
  assign run_b = driver_b_invert_when_on ? WAVE_INVERTED : WAVE_CARRIER;
  // Disabled drivers stay low with no conductance
  assign sif.wave_a = (!en_a || hold_low_a) ? WAVE_ZERO : run_a;
  assign sif.wave_b = (!en_b || hold_low_b) ? WAVE_ZERO : run_b;
  // Conductance choice: envelope high or forced unmodulated
  assign sif.unmod_a = env;
  assign sif.unmod_b = env || driver_b_always_unmodulated;
  assign sif.active_a = en_a;
  assign sif.active_b = en_b;
endmodule : antdrv_select
`default_nettype wire

//--- antdrv_top.sv
// Module: antenna driver output select with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module antdrv_top
  import antdrv_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Transmit envelope
  input wire logic ENVELOPE,
  // AXI4-Lite write channels
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read channels
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Antenna driver outputs
  output logic ANTENNA_PIN_A,
  output logic ANTENNA_PIN_B,
  output logic CARRIER_CLOCK,
  output logic [P_COND_W-1:0] P_COND_A,
  output logic [N_COND_W-1:0] N_COND_A,
  output logic [P_COND_W-1:0] P_COND_B,
  output logic [N_COND_W-1:0] N_COND_B
);
  // Software registers
  logic [7:0] ctrl;
  logic [P_COND_W-1:0] p_unmodulated_conductance_reg;
  logic [P_COND_W-1:0] p_keyed_conductance_reg;
  logic [7:0] n_conductance_reg;
  // Carrier divider and snapshot
  logic carrier_q;
  antdrv_snap_s snap;
  // Bus state
  logic aw_got;
  logic w_got;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // Known register offsets
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == CTRL_REG_OFS) || (a == P_UNMOD_REG_OFS) || (a == P_KEYED_REG_OFS)
      || (a == N_COND_REG_OFS) || (a == STATUS_REG_OFS);
  endfunction : reg_hit

  // Conductance fields
  wire [N_COND_W-1:0] n_unmodulated_field = n_conductance_reg[N_UNMOD_LSB +: N_COND_W];
  wire [N_COND_W-1:0] n_keyed_field = n_conductance_reg[N_KEYED_LSB +: N_COND_W];

  // Selection logic
  antdrv_sel_if sif ();
  assign sif.snap = snap;
  antdrv_select u_select (
    .sif (sif.sel)
  );

  // Carrier and its inverse as seen one edge ahead
  wire carrier_clock = carrier_q;
  wire carrier_clock_inverted = !carrier_q;
  wire carrier_rise = !carrier_q;

  // Waveform decode for each pin
  wire next_pin_a = (sif.wave_a == WAVE_CARRIER) ? carrier_clock :
    (sif.wave_a == WAVE_INVERTED) ? carrier_clock_inverted : 1'b0;
  wire next_pin_b = (sif.wave_b == WAVE_CARRIER) ? carrier_clock :
    (sif.wave_b == WAVE_INVERTED) ? carrier_clock_inverted : 1'b0;
  // Conductance choice, shared registers for both arrays
  wire [P_COND_W-1:0] next_p_a = !sif.active_a ? '0 :
    sif.unmod_a ? p_unmodulated_conductance_reg : p_keyed_conductance_reg;
  wire [N_COND_W-1:0] next_n_a = !sif.active_a ? '0 :
    sif.unmod_a ? n_unmodulated_field : n_keyed_field;
  wire [P_COND_W-1:0] next_p_b = !sif.active_b ? '0 :
    sif.unmod_b ? p_unmodulated_conductance_reg : p_keyed_conductance_reg;
  wire [N_COND_W-1:0] next_n_b = !sif.active_b ? '0 :
    sif.unmod_b ? n_unmodulated_field : n_keyed_field;

  // Divide by two
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      carrier_q <= 1'b0;
    end else begin
      carrier_q <= !carrier_q;
    end
  end

  // Snapshot taken once per carrier period
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      snap <= '{envelope: 1'b1, ctrl: CTRL_RST};
    end else if (carrier_rise) begin
      snap <= '{envelope: ENVELOPE, ctrl: ctrl};
    end
  end

  // Output flops, all updated on one edge
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ANTENNA_PIN_A <= 1'b0;
      ANTENNA_PIN_B <= 1'b0;
      CARRIER_CLOCK <= 1'b0;
      P_COND_A <= '0;
      N_COND_A <= '0;
      P_COND_B <= '0;
      N_COND_B <= '0;
    end else begin
      ANTENNA_PIN_A <= next_pin_a;
      ANTENNA_PIN_B <= next_pin_b;
      CARRIER_CLOCK <= carrier_clock;
      P_COND_A <= next_p_a;
      N_COND_A <= next_n_a;
      P_COND_B <= next_p_b;
      N_COND_B <= next_n_b;
    end
  end

  // Write path: address and data in either order
  wire do_write = aw_got && w_got && !S_AXI_BVALID;
  wire wr_lane0 = wstrb_q[0];
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= AXI_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= reg_hit(awaddr_q) ? AXI_OKAY : AXI_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // Register writes, low byte lane only
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ctrl <= CTRL_RST;
      p_unmodulated_conductance_reg <= P_UNMOD_RST;
      p_keyed_conductance_reg <= P_KEYED_RST;
      n_conductance_reg <= N_COND_RST;
    end else if (do_write && wr_lane0) begin
      case (awaddr_q)
        CTRL_REG_OFS: ctrl <= wdata_q[7:0];
        P_UNMOD_REG_OFS: p_unmodulated_conductance_reg <= wdata_q[P_COND_W-1:0];
        P_KEYED_REG_OFS: p_keyed_conductance_reg <= wdata_q[P_COND_W-1:0];
        N_COND_REG_OFS: n_conductance_reg <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // Read decode
  wire [31:0] status_word = {28'h0000000, carrier_q, ANTENNA_PIN_B, ANTENNA_PIN_A, snap.envelope};
  wire [31:0] rd_word = (S_AXI_ARADDR == CTRL_REG_OFS) ? {24'h000000, ctrl} :
    (S_AXI_ARADDR == P_UNMOD_REG_OFS) ? {26'h0, p_unmodulated_conductance_reg} :
    (S_AXI_ARADDR == P_KEYED_REG_OFS) ? {26'h0, p_keyed_conductance_reg} :
    (S_AXI_ARADDR == N_COND_REG_OFS) ? {24'h000000, n_conductance_reg} :
    (S_AXI_ARADDR == STATUS_REG_OFS) ? status_word : 32'h0000_0000;

  // Read path
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= AXI_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= reg_hit(S_AXI_ARADDR) ? AXI_OKAY : AXI_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  wire s_en_a = snap.ctrl[CTRL_A_EN_BIT];
  wire s_en_b = snap.ctrl[CTRL_B_EN_BIT];
  wire s_force = snap.ctrl[CTRL_FORCE_BIT];
  wire s_inv_a = snap.ctrl[CTRL_A_INV_ON_BIT];
  wire s_cw_b = snap.ctrl[CTRL_B_CW_BIT];
  wire s_inv_b = snap.ctrl[CTRL_B_INV_ON_BIT];

  property p_carrier_half;
    carrier_q |=> !carrier_q ##1 carrier_q;
  endproperty
  a_carrier_half: assert property (p_carrier_half) else $error("carrier not halved");

  property p_invert_a;
    (s_en_a && s_inv_a && snap.envelope) |=> (ANTENNA_PIN_A == !$past(carrier_q));
  endproperty
  a_invert_a: assert property (p_invert_a) else $error("pin A not inverted carrier");

  property p_force_a;
    (s_en_a && s_force && !snap.envelope) |=>
      (!ANTENNA_PIN_A && P_COND_A == $past(p_keyed_conductance_reg));
  endproperty
  a_force_a: assert property (p_force_a) else $error("pin A not held low in pause");

  property p_b_like_a;
    (s_en_b && !s_cw_b && !s_force && !s_inv_b && !snap.envelope) |=>
      (ANTENNA_PIN_B == $past(carrier_q) && N_COND_B == $past(n_keyed_field));
  endproperty
  a_b_like_a: assert property (p_b_like_a) else $error("pin B keyed wrong");

  property p_b_unmod;
    (s_en_b && s_cw_b && !s_inv_b) |=>
      (ANTENNA_PIN_B == $past(carrier_q) && P_COND_B == $past(p_unmodulated_conductance_reg));
  endproperty
  a_b_unmod: assert property (p_b_unmod) else $error("pin B not unmodulated");

  property p_n_unmod_a;
    (s_en_a && snap.envelope) |=> (N_COND_A == $past(n_unmodulated_field));
  endproperty
  a_n_unmod_a: assert property (p_n_unmod_a) else $error("N unmodulated field wrong");

  property p_n_keyed_a;
    (s_en_a && !snap.envelope) |=> (N_COND_A == $past(n_keyed_field));
  endproperty
  a_n_keyed_a: assert property (p_n_keyed_a) else $error("N keyed field wrong");

  property p_shared;
    (s_en_a && s_en_b && !s_cw_b) |=> (P_COND_A == P_COND_B && N_COND_A == N_COND_B);
  endproperty
  a_shared: assert property (p_shared) else $error("arrays differ");

  property p_off_a;
    !s_en_a |=> (!ANTENNA_PIN_A && P_COND_A == '0 && N_COND_A == '0);
  endproperty
  a_off_a: assert property (p_off_a) else $error("disabled pin A active");

  property p_snap;
    carrier_q |=> $stable(snap);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot moved mid period");

  property p_env_take;
    !carrier_q |=> (snap.envelope == $past(ENVELOPE));
  endproperty
  a_env_take: assert property (p_env_take) else $error("envelope not sampled");

  c_pause: cover property (s_en_a && s_force && !snap.envelope ##2 !ANTENNA_PIN_A);
  c_cw_b: cover property (s_en_b && s_cw_b && s_inv_b);
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule : antdrv_top
`default_nettype wire

//--- antdrv_net_model.sv
// Antenna matching network model: passive load on both driver pins
`timescale 1ns/1ps
`default_nettype none
module antdrv_net_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Driven pins
  input wire logic pin_a,
  input wire logic pin_b,
  // Field activity seen by the load
  output logic [15:0] swing_cnt
);
  logic prev_a;
  logic prev_b;
  // Count cycles with a transition on either pin as delivered field energy
  always_ff @(posedge clk) begin
    prev_a <= pin_a;
    prev_b <= pin_b;
    if (!nrst) swing_cnt <= 16'h0000;
    else swing_cnt <= swing_cnt + 16'((pin_a != prev_a) || (pin_b != prev_b));
  end
endmodule : antdrv_net_model
`default_nettype wire

//--- antenna_driver_output_select_tb.sv
// Testbench: driver output select, register bus and pin waveforms
`timescale 1ns/1ps
`default_nettype none
module antenna_driver_output_select_tb;
  import antdrv_pkg::*;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic ENVELOPE = 1'b1;
  logic [7:0] S_AXI_AWADDR = 8'h00;
  logic [7:0] S_AXI_ARADDR = 8'h00;
  logic S_AXI_AWVALID = 1'b0;
  logic S_AXI_WVALID = 1'b0;
  logic S_AXI_ARVALID = 1'b0;
  logic S_AXI_BREADY = 1'b1;
  logic S_AXI_RREADY = 1'b1;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic ANTENNA_PIN_A, ANTENNA_PIN_B, CARRIER_CLOCK;
  logic [P_COND_W-1:0] P_COND_A, P_COND_B;
  logic [N_COND_W-1:0] N_COND_A, N_COND_B;
  logic [15:0] swing_cnt;
  logic [5:0] p_un = 6'h3F;
  logic [5:0] p_ke = 6'h20;
  logic [7:0] n_rg = 8'h88;
  int miscompares = 0;
  int cmp_count = 0;

  // 40 MHz clock
  always #12.5 CLK = ~CLK;

  antdrv_top dut (
    .CLK, .NRST, .ENVELOPE,
    .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY,
    .ANTENNA_PIN_A, .ANTENNA_PIN_B, .CARRIER_CLOCK,
    .P_COND_A, .N_COND_A, .P_COND_B, .N_COND_B
  );

  antdrv_net_model load (
    .clk(CLK), .nrst(NRST), .pin_a(ANTENNA_PIN_A), .pin_b(ANTENNA_PIN_B),
    .swing_cnt(swing_cnt)
  );

  // Report and count one mismatch
  task automatic bad(input string m);
    miscompares++;
    $display("BAD %0t %s", $time, m);
  endtask : bad

  // Compare with four-state equality
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) bad(m);
  endtask : chk

  // Bus write, both channels offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int n;
    n = 0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= s;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID && n < 50);
    r = S_AXI_BRESP;
    if (n >= 50) bad("write hang");
  endtask : axi_wr

  // Bus read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID && n < 50);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    if (n >= 50) bad("read hang");
  endtask : axi_rd

  // Check pins, carrier and conductances over four cycles
  task automatic chk_out(input logic [7:0] c, input logic e);
    logic car, prv, ub;
    logic [10:0] ea, eb;
    ub = c[5] | e;
    for (int i = 0; i < 4; i++) begin
      @(negedge CLK);
      car = CARRIER_CLOCK;
      if (i > 0) chk(32'(car), 32'(!prv), "carrier not halved");
      prv = car;
      ea = !c[0] ? 11'h000 : {(c[2] && !e) ? 1'b0 : car ^ c[3],
                              e ? p_un : p_ke, e ? n_rg[7:4] : n_rg[3:0]};
      eb = !c[1] ? 11'h000 : {(c[2] && !ub) ? 1'b0 : car ^ c[6],
                              ub ? p_un : p_ke, ub ? n_rg[7:4] : n_rg[3:0]};
      chk(32'({ANTENNA_PIN_A, P_COND_A, N_COND_A}), 32'(ea), "pin a");
      chk(32'({ANTENNA_PIN_B, P_COND_B, N_COND_B}), 32'(eb), "pin b");
    end
    @(posedge CLK);
  endtask : chk_out

  // Reset values and unmapped read
  task automatic t_reset_vals;
    logic [7:0] ofs [4] = '{CTRL_REG_OFS, P_UNMOD_REG_OFS, P_KEYED_REG_OFS, N_COND_REG_OFS};
    logic [31:0] rv [4] = '{32'(CTRL_RST), 32'(P_UNMOD_RST), 32'(P_KEYED_RST), 32'(N_COND_RST)};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      axi_rd(ofs[i], d, r);
      chk(d, rv[i], "reset value");
      chk(32'(r), 32'(AXI_OKAY), "read resp");
    end
    axi_rd(8'h40, d, r);
    chk(32'(r), 32'(AXI_SLVERR), "unmapped read resp");
    chk(d, 32'h0, "unmapped read data");
  endtask : t_reset_vals

  // Program conductances, strobe and unmapped write
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(P_UNMOD_REG_OFS, 32'hFFFF_FFEA, 4'hF, r);
    axi_wr(P_KEYED_REG_OFS, 32'h0000_0015, 4'hF, r);
    axi_wr(N_COND_REG_OFS, 32'h0000_007C, 4'hF, r);
    p_un = 6'h2A;
    p_ke = 6'h15;
    n_rg = 8'h7C;
    axi_rd(P_UNMOD_REG_OFS, d, r);
    chk(d, 32'h0000_002A, "upper bits kept");
    axi_wr(P_KEYED_REG_OFS, 32'h0000_003E, 4'h0, r);
    axi_rd(P_KEYED_REG_OFS, d, r);
    chk(d, 32'h0000_0015, "strobe off stored");
    axi_wr(8'h40, 32'h0000_00FF, 4'hF, r);
    chk(32'(r), 32'(AXI_SLVERR), "unmapped write resp");
    axi_rd(CTRL_REG_OFS, d, r);
    chk(d, 32'h0, "unmapped write had effect");
  endtask : t_regs

  // Every control setting with both envelope levels
  task automatic t_sweep;
    logic [1:0] r;
    for (int c = 0; c < 256; c++) begin
      for (int e = 0; e < 2; e++) begin
        axi_wr(CTRL_REG_OFS, 32'(c), 4'hF, r);
        ENVELOPE <= e[0];
        repeat (4) @(posedge CLK);
        chk_out(c[7:0], e[0]);
      end
    end
  endtask : t_sweep

  // Conductance registers followed while driving
  task automatic t_live;
    logic [1:0] r;
    logic [31:0] d;
    axi_wr(N_COND_REG_OFS, 32'h0000_00A5, 4'hF, r);
    axi_wr(P_KEYED_REG_OFS, 32'h0000_0009, 4'hF, r);
    n_rg = 8'hA5;
    p_ke = 6'h09;
    ENVELOPE <= 1'b0;
    repeat (4) @(posedge CLK);
    chk_out(8'hFF, 1'b0);
    axi_rd(STATUS_REG_OFS, d, r);
    chk(32'(d[1:0]), 32'h0, "status pause and pin a low");
  endtask : t_live

  // Verdict and end of run
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    t_reset_vals();
    t_regs();
    t_sweep();
    t_live();
    chk(32'(swing_cnt != 16'h0000), 32'h1, "no field at load");
    complete_run();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge CLK);
    bad("watchdog expired");
    complete_run();
  end
endmodule : antenna_driver_output_select_tb
`default_nettype wire
